// file: core/sfcfe_pkg.sv
// shared constants for the serial flash command front end
package sfcfe_pkg;
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          CLK_NS          = 50;
  // opcodes; all but OP_STATUS_A and OP_STATUS_B start internal operations
  localparam logic [7:0]  OP_STATUS_A     = 8'h57;
  localparam logic [7:0]  OP_STATUS_B     = 8'hd7;
  localparam logic [7:0]  OP_XFER_B1      = 8'h53;
  localparam logic [7:0]  OP_XFER_B2      = 8'h55;
  localparam logic [7:0]  OP_CMP_B1       = 8'h60;
  localparam logic [7:0]  OP_CMP_B2       = 8'h61;
  localparam logic [7:0]  OP_EP_B1        = 8'h83;
  localparam logic [7:0]  OP_EP_B2        = 8'h86;
  localparam logic [7:0]  OP_PROG_B1      = 8'h88;
  localparam logic [7:0]  OP_PROG_B2      = 8'h89;
  localparam logic [7:0]  OP_BLK_ERASE    = 8'h50;
  // frame layout
  localparam int          OPC_BITS        = 8;
  localparam int          ADDR_BITS       = 24;
  localparam int          FRAME_BITS      = OPC_BITS + ADDR_BITS;
  localparam int          RSV_BITS        = 2;
  localparam int          PAGE_BITS       = 12;
  localparam int          OFS_BITS        = 10;
  localparam int          PAGE_EXT_BITS   = PAGE_BITS + RSV_BITS;
  // timing, in their own units
  localparam int          T_BUSY_NS       = 200;
  localparam int          T_XFR_US        = 250;
  localparam int          T_EP_MS         = 20;
  localparam int          T_P_MS          = 14;
  localparam int          T_BE_MS         = 12;
  localparam int          T_PWRUP_MS      = 20;
  localparam int          SCK_DIV         = 2;
  localparam int          CYC_BUSY        = (T_BUSY_NS / CLK_NS) < 1 ? 1
                                            : T_BUSY_NS / CLK_NS;
  localparam int          CYC_XFR         = T_XFR_US * (CLK_HZ / 1_000_000);
  localparam int          CYC_EP          = T_EP_MS * (CLK_HZ / 1000);
  localparam int          CYC_P           = T_P_MS * (CLK_HZ / 1000);
  localparam int          CYC_BE          = T_BE_MS * (CLK_HZ / 1000);
  localparam int          CYC_PWRUP       = T_PWRUP_MS * (CLK_HZ / 1000);
  localparam int          CNT_W           = 24;
  typedef enum logic [1:0] {
    SFCFE_OP_NONE  = 2'h0,
    SFCFE_OP_XFR   = 2'h1,
    SFCFE_OP_PROG  = 2'h2,
    SFCFE_OP_EP    = 2'h3
  } sfcfe_op_t;
endpackage : sfcfe_pkg

// file: core/sfcfe_if.sv
// spi link between master and flash front end
`timescale 1ns/1ps
interface sfcfe_if;
  logic cs_n;
  logic sck;
  logic si;
  logic reset_n;
  logic ready_n_busy;
  modport master (output cs_n, output sck, output si, output reset_n,
                  input ready_n_busy);
  modport flash (input cs_n, input sck, input si, input reset_n,
                 output ready_n_busy);
endinterface : sfcfe_if

// file: core/sfcfe_flash.sv
// flash-side spi command front end with busy timing
`timescale 1ns/1ps
// Behaviour
// [R1] works with spi mode 0 and 3
// [R2] frame starts on cs fall, either idle
// [R3] input bits sampled on sck rising edge
// [R4] master keeps cs high before reset release
// [R5] frame is opcode then 24 address bits
// [R6] master drives reserved bits as zero
// [R7] reserved bits extend page address upward
// [R8] master waits 20 ms before first command
// [R9] busy low within 200 ns of cs rise
// [R10] transfer/compare busy for 250 us
// [R11] erase-program 20, program 14, block 12 ms
// [R12] master keeps sck at or below 20 MHz
// [R13] reset aborts frame, back to idle
module sfcfe_flash
  import sfcfe_pkg::*;
#(
  parameter int XFR_CYC = CYC_XFR,
  parameter int EP_CYC  = CYC_EP,
  parameter int P_CYC   = CYC_P,
  parameter int BE_CYC  = CYC_BE
) (
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  sfcfe_if.flash                        link,
  output logic                          cmd_valid_o,
  output logic [7:0]                    cmd_opcode_o,
  output logic [PAGE_EXT_BITS-1:0]      page_select_bits_o,
  output logic [OFS_BITS-1:0]           byte_offset_bits_o,
  output logic                          busy_o
);
  typedef enum logic [1:0] {
    SFCFE_ST_IDLE  = 2'b00,
    SFCFE_ST_SHIFT = 2'b01,
    SFCFE_ST_DONE  = 2'b11
  } sfcfe_st_t;

  function automatic logic [CNT_W-1:0] op_cycles(input logic [7:0] op);
    logic [CNT_W-1:0] c;
    c = '0;
    unique case (op)
      OP_XFER_B1, OP_XFER_B2, OP_CMP_B1, OP_CMP_B2:
        c = CNT_W'(XFR_CYC); // [R10]
      OP_EP_B1, OP_EP_B2: c = CNT_W'(EP_CYC); // [R11]
      OP_PROG_B1, OP_PROG_B2: c = CNT_W'(P_CYC); // [R11]
      OP_BLK_ERASE: c = CNT_W'(BE_CYC); // [R11]
      default: c = '0;
    endcase
    return c;
  endfunction : op_cycles

  logic [2:0]             cs_sync_reg, sck_sync_reg, si_sync_reg, rst_sync_reg;
  logic [2:0]             cs_sync_next, sck_sync_next, si_sync_next;
  logic [2:0]             rst_sync_next;
  sfcfe_st_t              st_reg, st_next;
  logic [FRAME_BITS-1:0]  sh_reg, sh_next;
  logic [5:0]             bit_reg, bit_next;
  logic [CNT_W-1:0]       cnt_reg, cnt_next;
  logic                   busy_reg, busy_next;
  logic                   valid_reg, valid_next;
  logic [7:0]             opc_reg, opc_next;
  logic [PAGE_EXT_BITS-1:0] pg_reg, pg_next;
  logic [OFS_BITS-1:0]    ofs_reg, ofs_next;
  logic                   cs_fall, cs_rise, sck_rise, rst_low;

  always_comb begin
    cs_sync_next  = {cs_sync_reg[1:0], link.cs_n};
    sck_sync_next = {sck_sync_reg[1:0], link.sck};
    si_sync_next  = {si_sync_reg[1:0], link.si};
    rst_sync_next = {rst_sync_reg[1:0], link.reset_n};
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_sync_reg  <= 3'h7;
      sck_sync_reg <= 3'h0;
      si_sync_reg  <= 3'h0;
      rst_sync_reg <= 3'h0;
    end else begin
      cs_sync_reg  <= cs_sync_next;
      sck_sync_reg <= sck_sync_next;
      si_sync_reg  <= si_sync_next;
      rst_sync_reg <= rst_sync_next;
    end
  end

  // edges use stages 1 and 2 only; stage 0 feeds stage 1 alone
  // cs fall counts as a frame start whatever sck level is [R2]
  assign cs_fall  = cs_sync_reg[2] & ~cs_sync_reg[1]; // [R2]
  assign cs_rise  = ~cs_sync_reg[2] & cs_sync_reg[1];
  // only rising sck edges sample, so mode 0 and 3 both work [R1]
  assign sck_rise = ~sck_sync_reg[2] & sck_sync_reg[1]; // [R3]
  assign rst_low  = ~rst_sync_reg[1];

  always_comb begin
    st_next    = st_reg;
    sh_next    = sh_reg;
    bit_next   = bit_reg;
    cnt_next   = cnt_reg;
    busy_next  = busy_reg;
    valid_next = 1'b0;
    opc_next   = opc_reg;
    pg_next    = pg_reg;
    ofs_next   = ofs_reg;
    if (busy_reg) begin
      if (cnt_reg <= CNT_W'(1)) begin
        busy_next = 1'b0; // [R10] [R11]
        cnt_next  = '0;
      end else begin
        cnt_next = cnt_reg - CNT_W'(1);
      end
    end
    if (rst_low) begin
      st_next  = SFCFE_ST_IDLE; // [R13]
      bit_next = '0;
      sh_next  = '0;
    end else begin
      unique case (st_reg)
        SFCFE_ST_IDLE: begin
          if (cs_fall) begin
            st_next  = SFCFE_ST_SHIFT;
            bit_next = '0;
          end
        end
        SFCFE_ST_SHIFT: begin
          if (cs_rise) begin
            st_next = SFCFE_ST_IDLE;
          end else if (sck_rise) begin
            sh_next  = {sh_reg[FRAME_BITS-2:0], si_sync_reg[2]}; // [R3]
            bit_next = bit_reg + 6'h01;
            if (bit_reg == 6'(FRAME_BITS - 1)) begin
              st_next = SFCFE_ST_DONE; // [R5]
            end
          end
        end
        SFCFE_ST_DONE: begin
          if (cs_rise) begin
            st_next    = SFCFE_ST_IDLE;
            valid_next = 1'b1;
            opc_next   = sh_reg[FRAME_BITS-1 -: OPC_BITS]; // [R5]
            // reserved bits become upper page bits [R7]
            pg_next    = sh_reg[ADDR_BITS-1 -: PAGE_EXT_BITS]; // [R7]
            ofs_next   = sh_reg[OFS_BITS-1:0]; // [R5]
            if (!busy_reg && op_cycles(opc_next) != '0) begin
              busy_next = 1'b1; // [R9]
              cnt_next  = op_cycles(opc_next);
            end
          end
        end
        default: st_next = SFCFE_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg    <= SFCFE_ST_IDLE; // [R13]
      sh_reg    <= '0;
      bit_reg   <= '0;
      cnt_reg   <= '0;
      busy_reg  <= 1'b0;
      valid_reg <= 1'b0;
      opc_reg   <= 8'h00;
      pg_reg    <= '0;
      ofs_reg   <= '0;
    end else begin
      st_reg    <= st_next;
      sh_reg    <= sh_next;
      bit_reg   <= bit_next;
      cnt_reg   <= cnt_next;
      busy_reg  <= busy_next;
      valid_reg <= valid_next;
      opc_reg   <= opc_next;
      pg_reg    <= pg_next;
      ofs_reg   <= ofs_next;
    end
  end

  // ready/busy pin low while busy
  assign link.ready_n_busy = ~busy_reg; // [R9]
  assign cmd_valid_o        = valid_reg;
  assign cmd_opcode_o       = opc_reg;
  assign page_select_bits_o = pg_reg;
  assign byte_offset_bits_o = ofs_reg;
  assign busy_o             = busy_reg;
endmodule : sfcfe_flash

// file: core/sfcfe_master.sv
// spi master end that frames commands to the flash
`timescale 1ns/1ps
module sfcfe_master
  import sfcfe_pkg::*;
#(
  parameter int PWRUP_CYC = CYC_PWRUP,
  parameter bit CPOL      = 1'b0
) (
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  sfcfe_if.master                       link,
  input  wire logic                     req_valid_i,
  output logic                          req_ready_o,
  input  wire logic [7:0]               req_opcode_i,
  input  wire logic [PAGE_BITS-1:0]     page_select_bits_i,
  input  wire logic [OFS_BITS-1:0]      byte_offset_bits_i,
  output logic                          flash_ready_o
);
  typedef enum logic [1:0] {
    SFCFE_M_WAIT  = 2'b00,
    SFCFE_M_IDLE  = 2'b01,
    SFCFE_M_SHIFT = 2'b11,
    SFCFE_M_END   = 2'b10
  } sfcfe_m_t;

  sfcfe_m_t               st_reg, st_next;
  logic [CNT_W-1:0]       cnt_reg, cnt_next;
  logic [FRAME_BITS-1:0]  sh_reg, sh_next;
  logic [5:0]             bit_reg, bit_next;
  logic                   sck_reg, sck_next;
  logic                   cs_n_reg, cs_n_next;
  logic                   rstn_reg, rstn_next;
  logic                   lead_reg, lead_next;
  logic [1:0]             rdy_sync_reg;

  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    sh_next   = sh_reg;
    bit_next  = bit_reg;
    sck_next  = sck_reg;
    cs_n_next = cs_n_reg;
    rstn_next = rstn_reg;
    lead_next = lead_reg;
    unique case (st_reg)
      SFCFE_M_WAIT: begin
        // cs already high when reset is released [R4]
        rstn_next = 1'b1; // [R4]
        if (cnt_reg >= CNT_W'(PWRUP_CYC)) begin
          st_next  = SFCFE_M_IDLE; // [R8]
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      SFCFE_M_IDLE: begin
        sck_next = CPOL; // [R1]
        if (req_valid_i && rdy_sync_reg[1]) begin
          // reserved bits sent as zero [R6]
          sh_next   = {req_opcode_i, {RSV_BITS{1'b0}},
                       page_select_bits_i, byte_offset_bits_i}; // [R5] [R6]
          bit_next  = '0;
          lead_next = CPOL; // [R1]
          cs_n_next = 1'b0;
          st_next   = SFCFE_M_SHIFT;
        end
      end
      SFCFE_M_SHIFT: begin
        // sck toggles each clock, 10 MHz, under the limit [R12]
        sck_next = ~sck_reg; // [R12]
        if (sck_reg) begin
          // mode 3 keeps bit 31 over the leading falling edge
          if (lead_reg) begin
            lead_next = 1'b0; // [R1]
          end else if (bit_reg == 6'(FRAME_BITS - 1)) begin
            st_next = SFCFE_M_END;
          end else begin
            sh_next  = {sh_reg[FRAME_BITS-2:0], 1'b0};
            bit_next = bit_reg + 6'h01;
          end
        end
      end
      SFCFE_M_END: begin
        sck_next  = CPOL;
        cs_n_next = 1'b1;
        st_next   = SFCFE_M_IDLE;
      end
      default: st_next = SFCFE_M_WAIT;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg       <= SFCFE_M_WAIT;
      cnt_reg      <= '0;
      sh_reg       <= '0;
      bit_reg      <= '0;
      sck_reg      <= CPOL;
      cs_n_reg     <= 1'b1; // [R4]
      rstn_reg     <= 1'b0;
      lead_reg     <= 1'b0;
      rdy_sync_reg <= 2'h0;
    end else begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      sh_reg       <= sh_next;
      bit_reg      <= bit_next;
      sck_reg      <= sck_next;
      cs_n_reg     <= cs_n_next;
      rstn_reg     <= rstn_next;
      lead_reg     <= lead_next;
      rdy_sync_reg <= {rdy_sync_reg[0], link.ready_n_busy};
    end
  end

  assign link.cs_n    = cs_n_reg;
  assign link.sck     = sck_reg;
  assign link.si      = sh_reg[FRAME_BITS-1];
  assign link.reset_n = rstn_reg;
  assign req_ready_o  = (st_reg == SFCFE_M_IDLE) && rdy_sync_reg[1];
  assign flash_ready_o = rdy_sync_reg[1];
endmodule : sfcfe_master

// file: tb/sfcfe_monitor.sv
// assertions on the spi link between master and flash
`timescale 1ns/1ps
module sfcfe_monitor #(
  parameter int MAX_BUSY = 44
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic reset_n,
  input  wire logic ready_n_busy
);
  logic [7:0] rise_reg, rise_next, since_reg, since_next;
  logic [7:0] busy_reg, busy_next;
  logic       sck_reg;
  always_comb begin
    rise_next  = cs_n ? 8'h00 : rise_reg + {7'h00, sck & ~sck_reg};
    since_next = !cs_n ? 8'h00 : since_reg + {7'h00, since_reg != 8'hff};
    busy_next  = ready_n_busy ? 8'h00
                 : busy_reg + {7'h00, busy_reg != 8'hff};
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rise_reg  <= 8'h00;
      since_reg <= 8'h00;
      busy_reg  <= 8'h00;
      sck_reg   <= 1'b0;
    end else begin
      rise_reg  <= rise_next;
      since_reg <= since_next;
      busy_reg  <= busy_next;
      sck_reg   <= sck;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  busy_after_cs_a: assert property (
    $fell(ready_n_busy) |-> cs_n && since_reg <= 8'd6)
    else $error("busy fell too late after frame end");
  reset_cs_high_a: assert property (!reset_n |-> cs_n)
    else $error("select low while reset pin active");
  busy_min_hold_a: assert property (
    $fell(ready_n_busy) |-> !ready_n_busy [*8])
    else $error("busy released too early");
  busy_max_len_a: assert property (busy_reg <= MAX_BUSY)
    else $error("busy held too long");
  frame_bits_a: assert property ($rose(cs_n) |-> rise_reg == 8'd32)
    else $error("frame did not carry 32 clock rises");
  start_when_ready_a: assert property ($fell(cs_n) |-> ready_n_busy)
    else $error("frame started while busy");
  si_setup_a: assert property (
    $rose(sck) && !cs_n |-> $stable(si))
    else $error("data changed at sampling edge");
  idle_clock_low_a: assert property (cs_n |-> !sck)
    else $error("mode 0 clock not low while idle");
endmodule : sfcfe_monitor

// file: tb/sfcfe_tb.sv
// testbench joining master and flash ends in modes 0 and 3
`timescale 1ns/1ps
module sfcfe_tb;
  import sfcfe_pkg::*;
  logic        clk, reset_i;
  logic        req_valid [2], req_ready [2], cmd_valid [2], busy [2];
  logic        flash_rdy [2];
  logic [7:0]  req_op [2], cmd_op [2];
  logic [11:0] req_page [2];
  logic [9:0]  req_ofs [2], ofs_o [2];
  logic [13:0] page_o [2];
  int          mismatches, num_checks;
  for (genvar g = 0; g < 2; g++) begin : gl
    sfcfe_if link ();
    sfcfe_master #(.PWRUP_CYC(20), .CPOL(g)) sfcfe_master_inst (
      .clk_i(clk), .reset_i(reset_i), .link(link),
      .req_valid_i(req_valid[g]), .req_ready_o(req_ready[g]),
      .req_opcode_i(req_op[g]), .page_select_bits_i(req_page[g]),
      .byte_offset_bits_i(req_ofs[g]), .flash_ready_o(flash_rdy[g]));
    sfcfe_flash #(.XFR_CYC(20), .EP_CYC(40), .P_CYC(30), .BE_CYC(25))
      sfcfe_flash_inst (
      .clk_i(clk), .reset_i(reset_i), .link(link),
      .cmd_valid_o(cmd_valid[g]), .cmd_opcode_o(cmd_op[g]),
      .page_select_bits_o(page_o[g]), .byte_offset_bits_o(ofs_o[g]),
      .busy_o(busy[g]));
    if (g == 0) begin : mon
      sfcfe_monitor sfcfe_monitor_inst (
        .clk_i(clk), .reset_i(reset_i), .cs_n(link.cs_n),
        .sck(link.sck), .si(link.si), .reset_n(link.reset_n),
        .ready_n_busy(link.ready_n_busy));
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  function automatic int busy_len(input logic [7:0] op);
    case (op)
      OP_XFER_B1, OP_XFER_B2, OP_CMP_B1, OP_CMP_B2: return 20;
      OP_EP_B1, OP_EP_B2: return 40;
      OP_PROG_B1, OP_PROG_B2: return 30;
      OP_BLK_ERASE: return 25;
      default: return 0;
    endcase
  endfunction : busy_len
  task automatic start(input int l, input logic [7:0] op,
                       input logic [11:0] pg, input logic [9:0] of);
    @(negedge clk);
    req_valid[l] = 1'b1;
    req_op[l]    = op;
    req_page[l]  = pg;
    req_ofs[l]   = of;
    for (int n = 0; n < 3000 && req_ready[l] !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    req_valid[l] = 1'b0;
  endtask : start
  task automatic do_cmd(input int l, input logic [7:0] op,
                        input logic [11:0] pg, input logic [9:0] of);
    int b;
    int e;
    start(l, op, pg, of);
    for (int n = 0; n < 200 && cmd_valid[l] !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check(cmd_valid[l], 1'b1);
    check(cmd_op[l], op);
    check(page_o[l], {2'b00, pg});
    check(ofs_o[l], of);
    e = busy_len(op);
    b = 0;
    repeat (60) begin
      b += (busy[l] === 1'b1);
      @(posedge clk);
      #1;
    end
    check(b >= e - 1 && b <= e + 2, 1'b1);
    check(flash_rdy[l], 1'b1);
  endtask : do_cmd
  task automatic all_codes();
    logic [7:0] ops [13];
    ops = '{OP_XFER_B1, OP_XFER_B2, OP_CMP_B1, OP_CMP_B2, OP_EP_B1,
            OP_EP_B2, OP_PROG_B1, OP_PROG_B2, OP_BLK_ERASE, OP_STATUS_A,
            OP_STATUS_B, OP_XFER_B1, OP_BLK_ERASE};
    for (int i = 0; i < 13; i++)
      do_cmd(0, ops[i], i[0] ? 12'hfff : 12'h001 << i,
             i[0] ? 10'h3ff : 10'h200 >> i);
  endtask : all_codes
  task automatic mode3();
    check(gl[1].link.sck, 1'b1);
    check(gl[0].link.sck, 1'b0);
    do_cmd(1, OP_PROG_B1, 12'h5a5, 10'h2aa);
    do_cmd(1, OP_STATUS_B, 12'ha5a, 10'h155);
  endtask : mode3
  task automatic abort_frame();
    int seen;
    seen = 0;
    start(0, OP_EP_B1, 12'h123, 10'h045);
    repeat (20) @(negedge clk);
    reset_i = 1'b1;
    repeat (6) @(negedge clk);
    reset_i = 1'b0;
    repeat (150) begin
      @(posedge clk);
      #1;
      seen += (cmd_valid[0] === 1'b1);
    end
    check(seen, 0);
    do_cmd(0, OP_CMP_B2, 12'h800, 10'h001);
  endtask : abort_frame
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(20000 * 50);
    mismatches++;
    results();
  end
  initial begin
    mismatches = 0;
    num_checks = 0;
    reset_i    = 1'b1;
    for (int l = 0; l < 2; l++) begin
      req_valid[l] = 1'b0;
      req_op[l]    = 8'h00;
      req_page[l]  = 12'h000;
      req_ofs[l]   = 10'h000;
    end
    repeat (6) @(negedge clk);
    reset_i = 1'b0;
    all_codes();
    mode3();
    abort_frame();
    results();
  end
endmodule : sfcfe_tb
